// ==== common/swtp_consts.vh ====
`ifndef SWTP_CONSTS_VH
`define SWTP_CONSTS_VH
// register offsets (byte addresses, own control window in master 0 region)
`define SWTP_OFF_CTRL 12'hC00
`define SWTP_OFF_DEVID 12'hC04
`define SWTP_OFF_FEAT1 12'hC08
`define SWTP_OFF_FEAT3 12'hC0C
`define SWTP_OFF_STAT 12'hC10
`define SWTP_OFF_SYNC 12'hC14
// control register fields
`define SWTP_CTRL_EN 0
`define SWTP_CTRL_TIMESTAMP_ENABLE_CONTROL 1
`define SWTP_CTRL_RESET 32'h00000000
// stimulus address decode bits
`define SWTP_A_TSOFF 3
`define SWTP_A_UNMARK 4
`define SWTP_A_NDSEL 5
`define SWTP_A_NONDATA 6
`define SWTP_A_INVAR 7
`define SWTP_A_HALF 2
// port slot and page structure
`define SWTP_PORT_LSB 8
`define SWTP_MASTER_LSB 24
// packet type codes
`define SWTP_PK_DATA 4'h0
`define SWTP_PK_DATA_TS 4'h1
`define SWTP_PK_MDATA 4'h2
`define SWTP_PK_MDATA_TS 4'h3
`define SWTP_PK_FLAG 4'h4
`define SWTP_PK_FLAG_WITH_TIMESTAMP 4'h5
`define SWTP_PK_TRIGGER_EVENT_PACKET 4'h6
`define SWTP_PK_TRIGGER_WITH_TIMESTAMP 4'h7
`define SWTP_PK_LOST 4'h8
`define SWTP_PK_ALIGN 4'h9
`define SWTP_PK_VERSION 4'hA
`define SWTP_PK_TIMESTAMP_FREQUENCY_PACKET 4'hB
// size encoding of feature register one
`define SWTP_FEAT1_SZ32 4'h1
`define SWTP_FEAT1_SZ64 4'h2
`define SWTP_VERSION 32'h00000001
`endif

// ==== design/swtp_ts_counter.v ====
`timescale 1ns/1ps
`include "swtp_consts.vh"
module swtp_ts_counter #(
  parameter TS_W = 48
) (
  // clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // control
  input wire run_in,
  // count
  output reg [TS_W-1:0] ts_out
);
  // free-running timestamp count, held at zero while timestamps are off
  always @(posedge ref_clk_in) begin
    if (rst_in || !run_in) begin
      ts_out <= {TS_W{1'b0}};
    end else begin
      ts_out <= ts_out + {{(TS_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // swtp_ts_counter

// ==== design/swtp_decode.v ====
`timescale 1ns/1ps
`include "swtp_consts.vh"
module swtp_decode #(
  parameter MW = 2,
  parameter PW = 4
) (
  // stimulus address
  input wire [31:0] addr_in,
  // decoded fields
  output wire [MW-1:0] master_out,
  output wire [PW-1:0] port_out,
  output wire invar_out,
  output wire nondata_out,
  output wire reserved_out,
  output wire ts_req_out,
  output wire marked_out,
  output wire trigger_event_packet_out,
  output wire high_half_out
);
  // master above the 16MB boundary, port below it
  assign master_out = addr_in[`SWTP_MASTER_LSB +: MW];
  assign port_out = addr_in[`SWTP_PORT_LSB +: PW];
  // bit 7 class, bit 6/5 data vs non-data, bit 3 no timestamp, bit 4 mark or trigger
  assign invar_out = addr_in[`SWTP_A_INVAR];
  assign nondata_out = addr_in[`SWTP_A_NONDATA];
  assign reserved_out = addr_in[`SWTP_A_NONDATA] ? !addr_in[`SWTP_A_NDSEL] :
                        addr_in[`SWTP_A_NDSEL];
  assign ts_req_out = !addr_in[`SWTP_A_TSOFF];
  assign marked_out = !addr_in[`SWTP_A_NONDATA] && !addr_in[`SWTP_A_UNMARK];
  assign trigger_event_packet_out = addr_in[`SWTP_A_NONDATA] && addr_in[`SWTP_A_UNMARK];
  assign high_half_out = addr_in[`SWTP_A_HALF];
endmodule // swtp_decode

// ==== design/swtp_packetizer.v ====
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "swtp_consts.vh"
// Contract
// - stimulus space extends to as many as 256 masters of 65536 ports.
// - every master has the same port count, shown in the id register.
// - feature register three reports the number of masters.
// - each master region is 16MB-aligned, even with fewer ports.
// - fundamental size is 32 or 64 bits, shown in feature register one.
// - no packet payload is wider than the fundamental size.
// - 64-bit as two 32-bit transfers on 32-bit size gives two packets.
// - compressed payloads never grow beyond the fundamental size.
// - marked halves of one transaction are recombined atomically.
// - writes at low bits 0b100 are the second half of offset zero.
// - payload keeps bus significance, lowest byte at the bottom.
// - all eight data, marked, flag and trigger packet kinds are made.
// - an absent class's locations behave as the implemented class.
// - invariant-timing timestamps may be dropped under pressure.
// - a timestamp may be added where none was asked for.
// - no timestamps at all while timestamp enable is clear.
// - guaranteed, requested and enabled means a timestamp always.
// - the trace channel number equals the stimulus port number.
// - a dropped invariant write yields a lost-trace packet before resuming; here it waits for a cycle without a bus request.
// - sync gives alignment and version, frequency only with timestamps.
// - bits6:5=00 data, bits6:5=11 non-data, bit7 invariant, bit3 no timestamp.
// - sixteen 256-byte port slots per 4KB page, pages contiguous.
// - a dropped invariant write traces nothing except its trigger.
module swtp_packetizer #(
  parameter DW = 64,
  parameter MW = 2,
  parameter PW = 4,
  parameter TS_W = 48,
  parameter HAS_GUAR = 1,
  parameter HAS_INVAR = 1,
  parameter [31:0] NUM_PORTS = 32'h00000010,
  parameter [31:0] NUM_MASTERS = 32'h00000004,
  parameter [31:0] TIMESTAMP_FREQUENCY_PACKET_HZ = 32'h00989680,
  parameter [15:0] SYNC_PERIOD = 16'h0400
) (
  // clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // wishbone slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [31:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  input wire wb_last_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  // trace packet stream
  output reg pkt_valid_out,
  input wire pkt_ready_in,
  output reg [3:0] pkt_type_out,
  output reg [MW-1:0] pkt_master_out,
  output reg [PW-1:0] pkt_chan_out,
  output reg [DW-1:0] pkt_data_out,
  output reg [3:0] pkt_size_out,
  output reg pkt_ts_valid_out,
  output reg [TS_W-1:0] pkt_ts_out,
  output reg pkt_lost_known_out,
  // trigger event
  output reg trigger_event_packet_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_EMIT = 3'b010;
  localparam ST_ACK = 3'b100;

  // byte count of a lane-select pattern
  function [3:0] sel_bytes;
    input [3:0] s;
    begin
      sel_bytes = {3'h0, s[0]} + {3'h0, s[1]} + {3'h0, s[2]} + {3'h0, s[3]};
    end
  endfunction

  // shift bytes down to the lowest selected lane
  function [31:0] lane_align;
    input [31:0] d;
    input [3:0] s;
    begin
      if (s[0]) begin
        lane_align = d;
      end else if (s[1]) begin
        lane_align = {8'h00, d[31:8]};
      end else if (s[2]) begin
        lane_align = {16'h0000, d[31:16]};
      end else begin
        lane_align = {24'h000000, d[31:24]};
      end
    end
  endfunction

  reg [2:0] state;
  reg [31:0] ctrl;
  reg [31:0] lost_cnt;
  reg [15:0] sync_cnt;
  reg sync_pend;
  reg [1:0] sync_step;
  reg lost_pend;
  reg [MW-1:0] lost_master;
  reg half_valid;
  reg [31:0] half_data;
  reg [31:0] half_adr;
  reg [3:0] next_type;
  wire [MW-1:0] dec_master;
  wire [PW-1:0] dec_port;
  wire dec_invar;
  wire dec_nondata;
  wire dec_resv;
  wire dec_ts_req;
  wire dec_marked;
  wire dec_trigger_event_packet;
  wire dec_high;
  wire [TS_W-1:0] ts_now;
  wire ts_en;
  wire stim_hit;
  wire reg_hit;
  wire req;
  wire invar_eff;
  wire ts_take;
  wire out_free;
  wire combine;

  assign ts_en = ctrl[`SWTP_CTRL_TIMESTAMP_ENABLE_CONTROL];
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  // control window sits in master 0 port page reserved block
  assign reg_hit = (wb_adr_in[31:12] == 20'h00000) && (wb_adr_in[11:8] == 4'hC);
  assign stim_hit = !reg_hit;
  assign out_free = !pkt_valid_out || pkt_ready_in;
  // an absent class is handled as the one that exists
  assign invar_eff = (HAS_INVAR == 0) ? 1'b0 : (HAS_GUAR == 0) ? 1'b1 : dec_invar;
  // stamp only when enabled; invariant stamps only when the output is free
  assign ts_take = ts_en && dec_ts_req && (!invar_eff || out_free);
  // 32-bit low half of a 64-bit data transfer, marked or not, is held for its partner
  assign combine = (DW == 64) && !dec_nondata && !dec_high && !wb_last_in &&
                   (wb_sel_in == 4'hF);

  swtp_decode #(
    .MW(MW),
    .PW(PW)
  ) u_dec (
    .addr_in(wb_adr_in),
    .master_out(dec_master),
    .port_out(dec_port),
    .invar_out(dec_invar),
    .nondata_out(dec_nondata),
    .reserved_out(dec_resv),
    .ts_req_out(dec_ts_req),
    .marked_out(dec_marked),
    .trigger_event_packet_out(dec_trigger_event_packet),
    .high_half_out(dec_high)
  );

  swtp_ts_counter #(
    .TS_W(TS_W)
  ) u_ts (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .run_in(ts_en),
    .ts_out(ts_now)
  );

  // packet type from decoded access
  always @* begin
    next_type = `SWTP_PK_DATA;
    if (dec_nondata) begin
      next_type = dec_trigger_event_packet ? (ts_take ? `SWTP_PK_TRIGGER_WITH_TIMESTAMP : `SWTP_PK_TRIGGER_EVENT_PACKET) :
                  (ts_take ? `SWTP_PK_FLAG_WITH_TIMESTAMP : `SWTP_PK_FLAG);
    end else if (dec_marked) begin
      next_type = ts_take ? `SWTP_PK_MDATA_TS : `SWTP_PK_MDATA;
    end else begin
      next_type = ts_take ? `SWTP_PK_DATA_TS : `SWTP_PK_DATA;
    end
  end

  // sync period counter
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync_cnt <= 16'h0000;
    end else if (sync_cnt == SYNC_PERIOD) begin
      sync_cnt <= 16'h0000;
    end else begin
      sync_cnt <= sync_cnt + 16'h0001;
    end
  end

  // bus and packet engine
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      ctrl <= `SWTP_CTRL_RESET;
      lost_cnt <= 32'h00000000;
      sync_pend <= 1'b1;
      sync_step <= 2'b00;
      lost_pend <= 1'b0;
      lost_master <= {MW{1'b0}};
      half_valid <= 1'b0;
      half_data <= 32'h00000000;
      half_adr <= 32'h00000000;
      wb_dat_out <= 32'h00000000;
      wb_ack_out <= 1'b0;
      pkt_valid_out <= 1'b0;
      pkt_type_out <= 4'h0;
      pkt_master_out <= {MW{1'b0}};
      pkt_chan_out <= {PW{1'b0}};
      pkt_data_out <= {DW{1'b0}};
      pkt_size_out <= 4'h0;
      pkt_ts_valid_out <= 1'b0;
      pkt_ts_out <= {TS_W{1'b0}};
      pkt_lost_known_out <= 1'b0;
      trigger_event_packet_out <= 1'b0;
    end else begin
      wb_ack_out <= 1'b0;
      trigger_event_packet_out <= 1'b0;
      if (pkt_valid_out && pkt_ready_in) begin
        pkt_valid_out <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (out_free && sync_pend && !req) begin
            // alignment, version, then frequency when stamping
            pkt_valid_out <= 1'b1;
            pkt_ts_valid_out <= 1'b0;
            pkt_data_out <= {DW{1'b0}};
            pkt_size_out <= 4'h0;
            if (sync_step == 2'b00) begin
              pkt_type_out <= `SWTP_PK_ALIGN;
              sync_step <= 2'b01;
            end else if (sync_step == 2'b01) begin
              pkt_type_out <= `SWTP_PK_VERSION;
              pkt_data_out[31:0] <= `SWTP_VERSION;
              pkt_size_out <= 4'h4;
              sync_step <= ts_en ? 2'b10 : 2'b00;
              sync_pend <= ts_en;
            end else begin
              pkt_type_out <= `SWTP_PK_TIMESTAMP_FREQUENCY_PACKET;
              pkt_data_out[31:0] <= TIMESTAMP_FREQUENCY_PACKET_HZ;
              pkt_size_out <= 4'h4;
              sync_step <= 2'b00;
              sync_pend <= 1'b0;
            end
          end else if (out_free && lost_pend && !req) begin
            pkt_valid_out <= 1'b1;
            pkt_type_out <= `SWTP_PK_LOST;
            pkt_master_out <= lost_master;
            pkt_lost_known_out <= 1'b1;
            pkt_ts_valid_out <= 1'b0;
            pkt_size_out <= 4'h0;
            lost_pend <= 1'b0;
          end else if (req && reg_hit) begin
            // register access answers in one cycle
            wb_ack_out <= 1'b1;
            state <= ST_ACK;
            wb_dat_out <= 32'h00000000;
            if (wb_we_in && wb_adr_in[11:0] == `SWTP_OFF_CTRL) begin
              if (wb_sel_in[0]) begin
                ctrl[7:0] <= wb_dat_in[7:0];
              end
            end else if (!wb_we_in) begin
              case (wb_adr_in[11:0])
                `SWTP_OFF_CTRL: wb_dat_out <= ctrl;
                `SWTP_OFF_DEVID: wb_dat_out <= NUM_PORTS;
                `SWTP_OFF_FEAT1: wb_dat_out <= (DW == 64) ? {28'h0, `SWTP_FEAT1_SZ64} :
                                               {28'h0, `SWTP_FEAT1_SZ32};
                `SWTP_OFF_FEAT3: wb_dat_out <= NUM_MASTERS;
                `SWTP_OFF_STAT: wb_dat_out <= lost_cnt;
                `SWTP_OFF_SYNC: wb_dat_out <= {31'h0, sync_pend};
                default: wb_dat_out <= 32'h00000000;
              endcase
            end
          end else if (req && stim_hit) begin
            // stimulus writes; reads return zero, never a stale register value
            wb_dat_out <= 32'h00000000;
            if (!wb_we_in || !ctrl[`SWTP_CTRL_EN] || (dec_resv && !dec_nondata)) begin
              wb_ack_out <= 1'b1;
              state <= ST_ACK;
            end else if (combine && !(invar_eff && !out_free)) begin
              half_valid <= 1'b1;
              half_data <= wb_dat_in;
              half_adr <= wb_adr_in;
              wb_ack_out <= 1'b1;
              state <= ST_ACK;
            end else if (invar_eff && !out_free) begin
              // dropped: no trace, only the trigger, then a loss report
              trigger_event_packet_out <= dec_trigger_event_packet;
              lost_pend <= 1'b1;
              lost_master <= dec_master;
              lost_cnt <= lost_cnt + 32'h00000001;
              half_valid <= 1'b0;
              wb_ack_out <= 1'b1;
              state <= ST_ACK;
            end else if (out_free) begin
              pkt_valid_out <= 1'b1;
              pkt_type_out <= next_type;
              pkt_master_out <= dec_master;
              pkt_chan_out <= dec_port;
              pkt_ts_valid_out <= ts_take;
              pkt_ts_out <= ts_now;
              pkt_data_out <= {DW{1'b0}};
              trigger_event_packet_out <= dec_trigger_event_packet;
              if (dec_nondata) begin
                pkt_size_out <= 4'h0;
              end else if (DW == 64 && dec_high && half_valid &&
                           half_adr[31:3] == wb_adr_in[31:3]) begin
                // join the held low half atomically
                pkt_data_out[31:0] <= half_data;
                pkt_data_out[DW-1:DW-32] <= wb_dat_in;
                pkt_size_out <= 4'h8;
              end else begin
                // each 32-bit or narrower beat is its own packet
                pkt_data_out[31:0] <= lane_align(wb_dat_in, wb_sel_in);
                pkt_size_out <= sel_bytes(wb_sel_in);
              end
              half_valid <= 1'b0;
              wb_ack_out <= 1'b1;
              state <= ST_EMIT;
            end
          end
        end
        ST_EMIT: begin
          state <= ST_ACK;
        end
        ST_ACK: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // a new sync period wins over the clear at the end of the last sequence
      if (sync_cnt == SYNC_PERIOD) begin
        sync_pend <= 1'b1;
      end
    end
  end
endmodule // swtp_packetizer

// ==== dv/swtp_sink.sv ====
`timescale 1ns/1ps
module swtp_sink (
  // clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // pacing commanded by the bench
  input wire stall_in,
  input wire slow_in,
  // packet stream
  input wire pkt_valid_in,
  input wire [3:0] pkt_type_in,
  input wire [1:0] pkt_master_in,
  input wire [3:0] pkt_chan_in,
  input wire [3:0] pkt_size_in,
  input wire pkt_ts_valid_in,
  input wire [63:0] pkt_data_in,
  output reg pkt_ready_out
);
  logic [78:0] q[$];
  // ready drops on command, and every other cycle in slow mode
  always @(posedge ref_clk_in) begin
    if (rst_in) pkt_ready_out <= 1'b0;
    else pkt_ready_out <= !stall_in && !(slow_in && pkt_ready_out);
  end
  // keep every packet taken at an edge, oldest first
  always @(posedge ref_clk_in) begin
    if (!rst_in && pkt_valid_in && pkt_ready_out) begin
      q.push_back({pkt_type_in, pkt_master_in, pkt_chan_in, pkt_size_in, pkt_ts_valid_in,
                   pkt_data_in});
    end
  end
endmodule // swtp_sink

// ==== dv/swtp_packetizer_checker.sv ====
`timescale 1ns/1ps
`include "swtp_consts.vh"
module swtp_packetizer_checker #(
  parameter DW = 64,
  parameter PW = 4
) (
  // clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // wishbone
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [31:0] wb_adr_in,
  input wire [31:0] wb_dat_in,
  input wire wb_last_in,
  input wire wb_ack_out,
  // packet stream
  input wire pkt_valid_out,
  input wire pkt_ready_in,
  input wire [3:0] pkt_type_out,
  input wire [PW-1:0] pkt_chan_out,
  input wire [DW-1:0] pkt_data_out,
  input wire [3:0] pkt_size_out,
  input wire pkt_ts_valid_out,
  input wire trigger_event_packet_out
);
  reg en;
  reg timestamp_enable_control;
  // accepted writes, and the traced stimulus ones among them
  wire take = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;
  wire stim = take & en & (wb_adr_in[31:24] != 8'h00) & (wb_adr_in[6] == wb_adr_in[5]);
  wire guar = stim & ~wb_adr_in[7];
  // mirror of the enable bits in the control register
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      en <= 1'b0;
      timestamp_enable_control <= 1'b0;
    end else if (take && wb_adr_in == 32'h00000C00) begin
      en <= wb_dat_in[`SWTP_CTRL_EN];
      timestamp_enable_control <= wb_dat_in[`SWTP_CTRL_TIMESTAMP_ENABLE_CONTROL];
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_gwrite;
    guar && wb_last_in;
  endsequence
  sequence s_gdata;
    s_gwrite ##0 !wb_adr_in[6];
  endsequence
  sequence s_lo_half;
    guar && !wb_last_in && !wb_adr_in[6] && !wb_adr_in[2];
  endsequence
  // packet checks
  chk_valid_hold: assert property (pkt_valid_out && !pkt_ready_in |=> pkt_valid_out &&
    $stable(pkt_data_out) && $stable(pkt_type_out)) else $error("packet changed while held");
  chk_size_max: assert property (pkt_valid_out |-> pkt_size_out <= DW / 8)
    else $error("payload wider than fundamental size");
  chk_chan_port: assert property (s_gwrite |-> pkt_valid_out &&
    pkt_chan_out == wb_adr_in[PW+7:8]) else $error("channel differs from port");
  chk_type_decode: assert property (s_gwrite ##0 (!timestamp_enable_control || !wb_adr_in[3]) |->
    pkt_type_out == {1'b0, wb_adr_in[6], wb_adr_in[6] ~^ wb_adr_in[4], timestamp_enable_control & !wb_adr_in[3]})
    else $error("packet type does not follow address");
  chk_ts_guar: assert property (s_gwrite ##0 (timestamp_enable_control && !wb_adr_in[3]) |-> pkt_ts_valid_out)
    else $error("guaranteed timestamp missing");
  chk_ts_off: assert property (pkt_valid_out && !timestamp_enable_control |-> !pkt_ts_valid_out)
    else $error("timestamp while disabled");
  chk_timestamp_frequency_packet_gate: assert property (pkt_valid_out && pkt_type_out == `SWTP_PK_TIMESTAMP_FREQUENCY_PACKET |-> timestamp_enable_control)
    else $error("frequency packet while timestamps off");
  chk_byte_order: assert property (s_gdata ##0 !wb_adr_in[2] |->
    pkt_data_out[31:0] == wb_dat_in) else $error("low bytes out of order");
  chk_split_join: assert property (s_gdata ##0 wb_adr_in[2] |-> pkt_size_out == 4'h8 &&
    pkt_data_out[63:32] == wb_dat_in) else $error("split halves not joined");
  chk_half_held: assert property (s_lo_half |-> !$rose(pkt_valid_out))
    else $error("first half traced alone");
  chk_trigger_event_packet_pulse: assert property (stim && wb_adr_in[6:4] == 3'b111 |-> ##[0:2] trigger_event_packet_out)
    else $error("trigger event missing");
endmodule // swtp_packetizer_checker
bind swtp_packetizer swtp_packetizer_checker #(.DW(DW), .PW(PW)) swtp_packetizer_checker_inst (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_last_in(wb_last_in),
  .wb_ack_out(wb_ack_out), .pkt_valid_out(pkt_valid_out), .pkt_ready_in(pkt_ready_in),
  .pkt_type_out(pkt_type_out), .pkt_chan_out(pkt_chan_out), .pkt_data_out(pkt_data_out),
  .pkt_size_out(pkt_size_out), .pkt_ts_valid_out(pkt_ts_valid_out), .trigger_event_packet_out(trigger_event_packet_out));

// ==== dv/swtp_packetizer_test.sv ====
`timescale 1ns/1ps
`include "swtp_consts.vh"
module swtp_packetizer_test;
  logic ref_clk_in;
  logic rst_in;
  logic wb_cyc, wb_stb, wb_we, wb_last, stall, slow;
  logic [31:0] wb_adr, wb_dat, q;
  logic [3:0] wb_sel;
  wire [31:0] wb_dat_out;
  wire wb_ack_out, pkt_valid_out, pkt_ready, pkt_ts_valid_out, trigger_event_packet_out;
  wire [3:0] pkt_type_out, pkt_chan_out, pkt_size_out;
  wire [1:0] pkt_master_out;
  wire [63:0] pkt_data_out;
  wire [47:0] pkt_ts;
  wire lost_known;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_trigger_event_packet = 0;
  int k;
  logic [78:0] p;
  logic [15:0] rows [8];
  swtp_packetizer #(.DW(64), .MW(2), .PW(4), .SYNC_PERIOD(16'hFFFF)) swtp_packetizer_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat),
    .wb_last_in(wb_last), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .pkt_valid_out(pkt_valid_out), .pkt_ready_in(pkt_ready), .pkt_type_out(pkt_type_out),
    .pkt_master_out(pkt_master_out), .pkt_chan_out(pkt_chan_out), .pkt_data_out(pkt_data_out),
    .pkt_size_out(pkt_size_out), .pkt_ts_valid_out(pkt_ts_valid_out), .pkt_ts_out(pkt_ts),
    .pkt_lost_known_out(lost_known), .trigger_event_packet_out(trigger_event_packet_out));
  swtp_sink swtp_sink_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .stall_in(stall),
    .slow_in(slow), .pkt_valid_in(pkt_valid_out), .pkt_type_in(pkt_type_out),
    .pkt_master_in(pkt_master_out), .pkt_chan_in(pkt_chan_out), .pkt_size_in(pkt_size_out),
    .pkt_ts_valid_in(pkt_ts_valid_out), .pkt_data_in(pkt_data_out), .pkt_ready_out(pkt_ready));
  // clock
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  // hang guard and trigger pulse count
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (trigger_event_packet_out === 1'b1) n_trigger_event_packet <= n_trigger_event_packet + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; read data lands in q
  task automatic wb_cycle(input logic [31:0] a, input logic [31:0] d, input logic we,
                          input logic last);
    @(posedge ref_clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    wb_last <= last;
    do @(posedge ref_clk_in); while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  // oldest recorded packet, all ones when none arrives
  task automatic get_pkt();
    int n;
    n = 0;
    while (swtp_sink_inst.q.size() == 0 && n < 200) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (swtp_sink_inst.q.size() == 0) p = '1;
    else p = swtp_sink_inst.q.pop_front();
  endtask
  task automatic expect_idle();
    repeat (10) @(posedge ref_clk_in);
    check(swtp_sink_inst.q.size(), 0);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    rst_in = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_last, stall, slow} = 6'h00;
    {wb_adr, wb_dat, wb_sel} = 68'h0;
    rows = '{{8'h00, `SWTP_PK_MDATA_TS, 4'h4}, {8'h08, `SWTP_PK_MDATA, 4'h4},
             {8'h10, `SWTP_PK_DATA_TS, 4'h4}, {8'h18, `SWTP_PK_DATA, 4'h4},
             {8'h60, `SWTP_PK_FLAG_WITH_TIMESTAMP, 4'h0}, {8'h68, `SWTP_PK_FLAG, 4'h0},
             {8'h70, `SWTP_PK_TRIGGER_WITH_TIMESTAMP, 4'h0}, {8'h78, `SWTP_PK_TRIGGER_EVENT_PACKET, 4'h0}};
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    check({pkt_valid_out, wb_ack_out, trigger_event_packet_out}, 3'b000);
    get_pkt();
    check(p[78:75], `SWTP_PK_ALIGN);
    get_pkt();
    check({p[78:75], p[63:0]}, {`SWTP_PK_VERSION, 32'h0, `SWTP_VERSION});
    expect_idle();
    wb_cycle(`SWTP_OFF_DEVID, 32'h0, 1'b0, 1'b1);
    check(q, 32'h00000010);
    wb_cycle(`SWTP_OFF_FEAT1, 32'h0, 1'b0, 1'b1);
    check(q, `SWTP_FEAT1_SZ64);
    wb_cycle(`SWTP_OFF_FEAT3, 32'h0, 1'b0, 1'b1);
    check(q, 32'h00000004);
    wb_cycle(32'h01000018, 32'h0, 1'b0, 1'b1);
    check(q, 32'h0);
    wb_cycle(32'h00000C18, 32'h0, 1'b0, 1'b1);
    check(q, 32'h0);
    // stimulus writes before enable are acked and not traced
    wb_cycle(32'h01000018, 32'h11223344, 1'b1, 1'b1);
    expect_idle();
    wb_cycle(`SWTP_OFF_CTRL, 32'h00000003, 1'b1, 1'b1);
    slow <= 1'b1;
    // all eight data, marked, flag and trigger kinds, one port each, in master one
    for (int i = 0; i < 8; i++) begin
      wb_cycle(32'h01000000 | (i << 8) | rows[i][15:8], 32'h11223344, 1'b1, 1'b1);
      get_pkt();
      check(p[78:76], rows[i][7:5]);
      if (!rows[i][11]) check({p[75], p[64], |pkt_ts}, 3'b111);
      check(p[74:65], {2'b01, i[3:0], rows[i][3:0]});
      if (!rows[i][14]) check(p[31:0], 32'h11223344);
    end
    // a 64-bit write in two unmarked halves
    wb_cycle(32'h01000018, 32'h55667788, 1'b1, 1'b0);
    wb_cycle(32'h0100001C, 32'h11223344, 1'b1, 1'b1);
    get_pkt();
    check({p[78:76], p[68:65], p[63:0]}, {3'b000, 4'h8, 64'h1122334455667788});
    expect_idle();
    // requested timestamp with timestamps off
    wb_cycle(`SWTP_OFF_CTRL, 32'h00000001, 1'b1, 1'b1);
    wb_cycle(32'h01000010, 32'h11223344, 1'b1, 1'b1);
    get_pkt();
    check({p[78:75], p[64], pkt_ts}, {`SWTP_PK_DATA, 1'b0, 48'h0});
    // invariant writes against a stalled sink
    slow <= 1'b0;
    stall <= 1'b1;
    wb_cycle(32'h01000098, 32'hA5A5A5A5, 1'b1, 1'b1);
    wb_cycle(32'h01000098, 32'h5A5A5A5A, 1'b1, 1'b1);
    k = n_trigger_event_packet;
    wb_cycle(32'h010000F8, 32'h0, 1'b1, 1'b1);
    repeat (3) @(posedge ref_clk_in);
    check(n_trigger_event_packet - k, 1);
    stall <= 1'b0;
    get_pkt();
    check({p[78:75], p[31:0]}, {`SWTP_PK_DATA, 32'hA5A5A5A5});
    get_pkt();
    check({p[78:75], p[74:73], lost_known}, {`SWTP_PK_LOST, 2'b01, 1'b1});
    expect_idle();
    final_report();
  end
endmodule // swtp_packetizer_test
